// [design/host_cpu_port.v]
/*
 asynchronous 16-bit host cpu port, both strobe styles on shared pins.
 assumes the host leaves select high two clocks after each write and
 that register read data comes from same-clock logic.
*/
// Behaviour
// R1: both bus styles, no mode pin
// R2: direction style: oe tied low, select qualifies
// R3: two-strobe style: read on oe, write on we
// R4: drive read data once read is qualified
// R5: capture write on rising we or select
// R6: move preload to register within two clocks
// R7: host idles select two clocks after write
// R8: data bus released unless read qualified
`timescale 1ns/100ps
`include "host_port_defines.vh"
module host_cpu_port #(
    parameter DATA_W = `HP_DATA_W,
    parameter ADDR_W = `HP_ADDR_W
) (
    input wire I_CLK,
    input wire I_ARST_N,
    input wire I_CS_N,
    input wire I_RW_N,
    input wire I_OE_N,
    input wire [ADDR_W-1:0] I_ADDR,
    input wire [DATA_W-1:0] I_DATA,
    input wire [DATA_W-1:0] I_RD_DATA,
    output reg [DATA_W-1:0] O_DATA,
    output reg O_DATA_OE,
    output reg [ADDR_W-1:0] O_RD_ADDR,
    output reg O_WR_STB,
    output reg [ADDR_W-1:0] O_WR_ADDR,
    output reg [DATA_W-1:0] O_WR_DATA
);
    // write tracking states; binary coded
    localparam ST_IDLE = 2'b00;
    localparam ST_WR = 2'b01;
    localparam ST_XFER = 2'b10;

    // stage one of each synchroniser; read only by stage two
    reg cs_s1_r;
    reg rw_s1_r;
    reg oe_s1_r;
    reg [ADDR_W-1:0] addr_s1_r;
    reg [DATA_W-1:0] data_s1_r;

    // stage two; the only copy that logic may read
    reg cs_s2_r;
    reg rw_s2_r;
    reg oe_s2_r;
    reg [ADDR_W-1:0] addr_s2_r;
    reg [DATA_W-1:0] data_s2_r;

    // write tracking and pre-load holding register
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [ADDR_W-1:0] pre_addr_r;
    reg [ADDR_W-1:0] pre_addr_nxt;
    reg [DATA_W-1:0] pre_data_r;
    reg [DATA_W-1:0] pre_data_nxt;

    // next values of the internal write port
    reg wr_stb_nxt;
    reg [ADDR_W-1:0] wr_addr_nxt;
    reg [DATA_W-1:0] wr_data_nxt;

    // read path
    reg rd_d_r;
    reg rd_d_nxt;
    reg data_oe_nxt;

    wire wr_act;
    wire rd_act;
    wire xfer;

    // read: select and output enable low, direction high
    function read_qual;
        input cs_n;
        input oe_n;
        input rw_n;
        begin
            read_qual = ~cs_n & ~oe_n & rw_n;
        end
    endfunction

    // write: select and write strobe low; oe plays no part
    function write_qual;
        input cs_n;
        input rw_n;
        begin
            write_qual = ~cs_n & ~rw_n;
        end
    endfunction

    // oe tied low in direction style, so one decode serves both
    assign rd_act = read_qual(cs_s2_r, oe_s2_r, rw_s2_r); // R1 R4
    assign wr_act = write_qual(cs_s2_r, rw_s2_r); // R1
    assign xfer = (state_r == ST_XFER); // R6

    // control pins
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            rw_s1_r <= 1'b1;
            rw_s2_r <= 1'b1;
            oe_s1_r <= 1'b1;
            oe_s2_r <= 1'b1;
        end else begin
            cs_s1_r <= I_CS_N;
            cs_s2_r <= cs_s1_r;
            rw_s1_r <= I_RW_N;
            rw_s2_r <= rw_s1_r;
            oe_s1_r <= I_OE_N;
            oe_s2_r <= oe_s1_r;
        end
    end

    // per-bit sync only safe as host holds address steady
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            addr_s1_r <= `HP_ADDR_RST;
            addr_s2_r <= `HP_ADDR_RST;
        end else begin
            addr_s1_r <= I_ADDR;
            addr_s2_r <= addr_s1_r;
        end
    end

    // same limitation for write data
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            data_s1_r <= `HP_DATA_RST;
            data_s2_r <= `HP_DATA_RST;
        end else begin
            data_s1_r <= I_DATA;
            data_s2_r <= data_s1_r;
        end
    end

    // whichever of we or select rises first ends the write
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (wr_act) begin
                    state_nxt = ST_WR;
                end
            end
            ST_WR: begin
                if (!wr_act) begin
                    state_nxt = ST_XFER; // R5
                end
            end
            ST_XFER: begin
                if (wr_act) begin
                    state_nxt = ST_WR;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // preload tracks the bus while strobed; frozen at the end
    always @* begin
        pre_addr_nxt = pre_addr_r;
        pre_data_nxt = pre_data_r;
        if (wr_act) begin
            pre_addr_nxt = addr_s2_r; // R5
            pre_data_nxt = data_s2_r; // R5
        end
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state_r <= ST_IDLE;
            pre_addr_r <= `HP_ADDR_RST;
            pre_data_r <= `HP_DATA_RST;
        end else begin
            state_r <= state_nxt;
            pre_addr_r <= pre_addr_nxt;
            pre_data_r <= pre_data_nxt;
        end
    end

    // transfer one clock after capture, done inside two clocks
    always @* begin
        wr_stb_nxt = xfer; // R6
        wr_addr_nxt = O_WR_ADDR;
        wr_data_nxt = O_WR_DATA;
        if (xfer) begin
            wr_addr_nxt = pre_addr_r; // R6
            wr_data_nxt = pre_data_r; // R6
        end
    end

    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_WR_STB <= 1'b0;
            O_WR_ADDR <= `HP_ADDR_RST;
            O_WR_DATA <= `HP_DATA_RST;
        end else begin
            O_WR_STB <= wr_stb_nxt;
            O_WR_ADDR <= wr_addr_nxt;
            O_WR_DATA <= wr_data_nxt;
        end
    end

    // enable waits one clock more so data matches the address;
    // costs a cycle of access time, never drives stale data
    always @* begin
        rd_d_nxt = rd_act;
        data_oe_nxt = rd_d_r & rd_act; // R4 R8
    end

    // idle gap from host keeps write and read apart
    always @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            O_RD_ADDR <= `HP_ADDR_RST;
            O_DATA <= `HP_DATA_RST;
            rd_d_r <= 1'b0;
            O_DATA_OE <= 1'b0;
        end else begin
            O_RD_ADDR <= addr_s2_r;
            O_DATA <= I_RD_DATA; // R4
            rd_d_r <= rd_d_nxt;
            O_DATA_OE <= data_oe_nxt; // R4 R8
        end
    end
endmodule

// [design/host_port_defines.vh]
/*
 host port constants: widths, timing counts, reset values.
 assumes a 50 MHz system clock.
*/
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH
`define HP_DATA_W 16
`define HP_ADDR_W 8
`define HP_CLK_NS 20
`define HP_XFER_CYC 2
`define HP_DATA_RST 16'h0000
`define HP_ADDR_RST 8'h00
`endif

// [sim/dual_timing_host_cpu_port_test.sv]
/* bench; host model drives, a watcher pops expected results */
`timescale 1ns/100ps
module dual_timing_host_cpu_port_test;
reg I_CLK = 0, I_ARST_N = 0;
reg [15:0] r = 16'h0037;
int errors = 0, checks_done = 0, i;
logic [23:0] q[$];
wire I_CS_N, I_RW_N, I_OE_N, O_DATA_OE, O_WR_STB;
wire [7:0] I_ADDR, O_RD_ADDR, O_WR_ADDR;
wire [15:0] I_DATA, O_DATA, O_WR_DATA, I_RD_DATA = {O_RD_ADDR, ~O_RD_ADDR};
always #10 I_CLK = ~I_CLK;
reg oe_q = 1'b0;
hp_host host (.I_CLK(I_CLK), .I_CS_N(I_CS_N), .I_RW_N(I_RW_N),
    .I_OE_N(I_OE_N), .I_ADDR(I_ADDR), .I_DATA(I_DATA));
host_cpu_port DUT (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_CS_N(I_CS_N),
    .I_RW_N(I_RW_N), .I_OE_N(I_OE_N), .I_ADDR(I_ADDR), .I_DATA(I_DATA),
    .I_RD_DATA(I_RD_DATA), .O_DATA(O_DATA), .O_DATA_OE(O_DATA_OE),
    .O_RD_ADDR(O_RD_ADDR), .O_WR_STB(O_WR_STB), .O_WR_ADDR(O_WR_ADDR),
    .O_WR_DATA(O_WR_DATA));
function [15:0] nxt(input [15:0] v);
    nxt = {v[14:0], ^(v & 16'hb400)}; endfunction
task chk(input [23:0] g, input [8*5:1] k); checks_done++;
    if (q.size() == 0 || q.pop_front() !== g) begin errors++;
        $display("MISMATCH %0t %0s", $time, k); end
endtask
task chk_wr(input [23:0] g); chk(g, "write"); endtask
task chk_rd(input [15:0] g); chk({8'h00, g}, "read"); endtask
task summarize; if (q.size() != 0) errors++;
    $display("%0d checks %0d errors", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish; endtask
always @(negedge I_CLK) begin oe_q <= O_DATA_OE;
    if (O_WR_STB === 1'b1) chk_wr({O_WR_ADDR, O_WR_DATA});
    if (O_DATA_OE === 1'b1 && oe_q === 1'b0) chk_rd(O_DATA); end
initial begin repeat (6) @(posedge I_CLK); I_ARST_N <= 1'b1; end
initial begin repeat (9) @(posedge I_CLK);
    for (i = 0; i < 8; i++) begin r = nxt(r);
        q.push_back({r[15:8], r}); host.wr(r[15:8], r, i[0]);
        q.push_back({8'h00, r[7:0], ~r[7:0]}); host.rd(r[7:0], i[0]);
        $display("pair %0d", i); end
    summarize; end
initial begin #20us errors++; summarize; end
endmodule

// [sim/hp_host.sv]
/* host cpu model; pins move only just after a clock edge */
`timescale 1ns/100ps
module hp_host (input wire I_CLK, output reg I_CS_N = 1, I_RW_N = 1,
    I_OE_N = 1, output reg [7:0] I_ADDR = 8'h00,
    output reg [15:0] I_DATA = 16'h0000);
task cyc(input int n); repeat (n) @(posedge I_CLK); endtask
task wr(input [7:0] a, input [15:0] v, input s);
    {I_CS_N, I_RW_N, I_OE_N, I_ADDR, I_DATA} <= {2'b00, s, a, v};
    cyc(4); {I_CS_N, I_RW_N} <= {!s, s}; cyc(1);
    {I_CS_N, I_RW_N, I_DATA} <= {2'b11, ~v}; cyc(3); endtask
task rd(input [7:0] a, input s);
    {I_CS_N, I_OE_N, I_ADDR} <= {2'b00, a}; cyc(5);
    {I_CS_N, I_OE_N} <= {1'b1, s}; cyc(4); endtask
endmodule

// [sim/hp_props.sv]
/* pin checks; sees only the top ports, bound below */
`timescale 1ns/100ps
module hp_props (input wire I_CLK, I_ARST_N, I_CS_N, I_RW_N, I_OE_N,
    O_DATA_OE, O_WR_STB);
default clocking @(posedge I_CLK); endclocking
default disable iff (!I_ARST_N);
wire rd = !I_CS_N && !I_OE_N && I_RW_N, wr = !I_CS_N && !I_RW_N;
sequence wr_end; wr ##1 !wr; endsequence
sequence rd_held; rd [*5]; endsequence
a_rd_drive: assert property (rd_held |-> O_DATA_OE) else $error("late");
a_bus_idle: assert property (O_DATA_OE |-> $past(rd, 3))
    else $error("stray drive");
a_wr_xfer: assert property (wr_end |-> ##[1:4] O_WR_STB)
    else $error("write lost");
a_stb_pulse: assert property (O_WR_STB |=> !O_WR_STB)
    else $error("long strobe");
a_wr_quiet: assert property (wr [*4] |-> !O_DATA_OE)
    else $error("drive in write");
a_idle_quiet: assert property (I_CS_N [*4] |-> !O_DATA_OE)
    else $error("drive while idle");
endmodule
bind host_cpu_port hp_props u_props (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_CS_N(I_CS_N), .I_RW_N(I_RW_N), .I_OE_N(I_OE_N),
    .O_DATA_OE(O_DATA_OE), .O_WR_STB(O_WR_STB));
